// File: core/dacr_pkg.sv
/*
  Shared constants for the clock and reset generator: register offsets,
  reset values, audio source and rate codes, timing figures.
  Assumes a 40 MHz system clock standing in for the crystal domain.
*/
package dacr_pkg;

  // clock figures
  localparam int unsigned SYS_CLK_HZ      = 40000000;
  localparam int unsigned XTAL_HZ         = 41600000;
  localparam int unsigned XTAL_REF_DIV    = 4;

  // core pll
  localparam int unsigned CORE_STEP_HZ    = 650000;
  localparam int unsigned CORE_M_BASE     = 212;
  localparam logic [7:0]  CORE_MSEL_RST   = 8'hbc;
  localparam logic [1:0]  CORE_DSEL_RST   = 2'h2;
  localparam int unsigned CORE_DSEL_MAX   = 3;

  // register offsets (host port)
  localparam logic [23:0] OFS_CORE_RUN    = 24'h000010;
  localparam logic [23:0] OFS_CORE_PLL    = 24'h000020;
  localparam logic [23:0] OFS_CLK_ENABLE  = 24'h000050;
  localparam logic [23:0] OFS_TUNER_CTL   = 24'h000060;
  localparam logic [23:0] OFS_AUDIO_CTL   = 24'h000070;
  localparam logic [23:0] OFS_STATUS      = 24'h000080;

  // reset values
  localparam logic [23:0] CORE_RUN_RST    = 24'h000000;
  localparam logic [7:0]  CLK_ENABLE_RST  = 8'hff;
  localparam logic [3:0]  TUNER_CUR_RST   = 4'h4;
  localparam logic        TUNER_FAST_RST  = 1'b0;
  localparam logic [1:0]  AUDIO_SRC_RST   = 2'h0;
  localparam logic [1:0]  AUDIO_RATE_RST  = 2'h1;
  localparam logic [1:0]  AUDIO_MULT_RST  = 2'h0;

  // audio codes
  typedef enum logic [1:0] {
    DACR_SRC_XTAL = 2'h0,
    DACR_SRC_WS   = 2'h1,
    DACR_SRC_SYS  = 2'h2
  } dacr_src_e;
  localparam logic [1:0]  RATE_44K1       = 2'h0;
  localparam logic [1:0]  RATE_48K        = 2'h1;
  localparam logic [1:0]  RATE_96K        = 2'h2;
  localparam int unsigned AUDIO_OUT_MULT  = 512;
  localparam int unsigned AUDIO_TOL_PCT   = 20;

  // tuner clock
  localparam int unsigned TUNER_SLOW_HZ   = 100000;
  localparam int unsigned TUNER_FAST_HZ   = 400000;
  localparam int unsigned TUNER_SLOW_HALF = SYS_CLK_HZ / (2 * TUNER_SLOW_HZ);
  localparam int unsigned TUNER_FAST_HALF = SYS_CLK_HZ / (2 * TUNER_FAST_HZ);

  // reset sequence
  localparam int unsigned RST_MIN_LOW     = 40;
  localparam int unsigned RST_POST_LOCK   = 2047;
  localparam int unsigned RST_TOTAL_NS    = 1000000;
  localparam int unsigned SYS_PERIOD_NS   = 25;
  localparam int unsigned RST_TOTAL_CYC   = RST_TOTAL_NS / SYS_PERIOD_NS;

  // source loss: no edge for this many cycles means the source stopped
  localparam int unsigned SRC_LOSS_CYC    = 2048;

endpackage : dacr_pkg

// File: core/dacr_sync2.sv
/*
  Two-flop synchroniser for one level coming from a pin.
  Assumes the destination runs on i_sys_clk; the first flop is read only
  by the second.
*/
`timescale 1ns/100ps
`default_nettype none
module dacr_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // data
  input  wire logic i_async,
  output var  logic o_sync
);
  logic meta_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : dacr_sync2
`default_nettype wire

// File: core/dacr_clock_reset.sv
/*
  Clock control and reset sequencing for a radio and audio processor:
  core pll settings, audio pll source selection with fallback, tuner
  reference divider and the power-on reset sequencer.
  Assumes i_sys_clk is the crystal-domain clock; analog plls live outside
  and report lock; pins pass through two-flop synchronisers.
// Behaviour
// - crystal divided by four feeds core pll
// - core post-divider of two, four or eight
// - core clock follows multiplier and divider formula
// - defaults give 130 MHz pll output
// - host writes multiplier and divider registers
// - audio clock is 512 times sample rate
// - crystal source presets 44.1/48/96 kHz targets
// - word clock source locks, yields 512 fs
// - system-rate source 256/384/512 fs accepted
// - lost external source falls back to crystal
// - external rate may deviate twenty percent
// - tuner reference 100 or 400 kHz divided
// - tuner clock retimed on crystal clock
// - tuner drive current is register programmable
// - reset starts low, ends about 1 ms
// - low pulses under forty clocks ignored
// - hold reset 2047 clocks after both locks
// - reset returns all registers to defaults
// - core counters held until run-control written
// - reset pin active low with pull-up
// - master mode derives rate from crystal
// - per-block clock enables gate clocks
*/
`timescale 1ns/100ps
`default_nettype none
module dacr_clock_reset
  import dacr_pkg::*;
#(
  parameter int unsigned POST_LOCK_CYC = RST_POST_LOCK,
  parameter int unsigned LOSS_CYC      = SRC_LOSS_CYC
) (
  // clock and pin reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_external_reset_low,
  // host register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [23:0] i_reg_addr,
  input  wire logic [23:0] i_reg_wdata,
  output var  logic [23:0] o_reg_rdata,
  output var  logic        o_reg_rvalid,
  // pll interface
  input  wire logic        i_core_pll_lock,
  input  wire logic        i_audio_pll_lock,
  output var  logic        o_core_ref_clk,
  output var  logic [7:0]  o_core_msel,
  output var  logic [1:0]  o_core_dsel,
  output var  logic [8:0]  o_core_mult,
  output var  logic [1:0]  o_audio_src,
  output var  logic [1:0]  o_audio_rate,
  output var  logic [1:0]  o_audio_in_mult,
  output var  logic        o_audio_fallback,
  // external audio references
  input  wire logic        i_host_word_clock_input,
  input  wire logic        i_system_rate_input,
  // tuner reference
  output var  logic        o_tuner_clk_p,
  output var  logic        o_tuner_clk_n,
  output var  logic [3:0]  o_tuner_current,
  // block clock enables and reset outputs
  output var  logic [7:0]  o_clk_enable,
  output var  logic        o_int_rstn,
  output var  logic        o_init_state,
  output var  logic        o_core_run_hold
);

  typedef enum logic [3:0] {
    DACR_ST_IDLE = 4'b0001,
    DACR_ST_LOW  = 4'b0010,
    DACR_ST_WAIT = 4'b0100,
    DACR_ST_RUN  = 4'b1000
  } dacr_state_e;

  // pin synchronisers
  logic pin_rstn_s;
  logic ws_s;
  logic fsys_s;

  // pin idles high, as if pulled up
  dacr_sync2 #(.RST_VAL(1'b1)) u_sync_rst (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_external_reset_low),
    .o_sync    (pin_rstn_s)
  );
  dacr_sync2 #(.RST_VAL(1'b0)) u_sync_ws (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_host_word_clock_input),
    .o_sync    (ws_s)
  );
  dacr_sync2 #(.RST_VAL(1'b0)) u_sync_fsys (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_system_rate_input),
    .o_sync    (fsys_s)
  );

  // reset sequencer
  dacr_state_e st_r;
  dacr_state_e st_nxt;
  logic [5:0]  low_cnt_r;
  logic [11:0] lock_cnt_r;
  logic        both_lock;
  logic        low_valid;
  logic        lock_done;
  logic        seq_rst;

  assign both_lock = i_core_pll_lock & i_audio_pll_lock;
  // forty low cycles make a valid reset
  assign low_valid = (low_cnt_r >= 6'(RST_MIN_LOW - 1)) & ~pin_rstn_s;
  assign lock_done = (lock_cnt_r >= 12'(POST_LOCK_CYC)) & both_lock;
  // registers return to defaults on either reset
  assign seq_rst   = !i_rstn || (st_r == DACR_ST_LOW);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DACR_ST_IDLE: begin
        // the pin held low for forty cycles starts a sequence
        if (!pin_rstn_s) begin
          st_nxt = DACR_ST_IDLE;
        end
        if (low_valid) begin
          st_nxt = DACR_ST_LOW;
        end
      end
      DACR_ST_LOW: begin
        if (pin_rstn_s) begin
          st_nxt = DACR_ST_WAIT;
        end
      end
      DACR_ST_WAIT: begin
        if (!pin_rstn_s && low_valid) begin
          st_nxt = DACR_ST_LOW;
        end else if (lock_done) begin
          st_nxt = DACR_ST_RUN;
        end
      end
      DACR_ST_RUN: begin
        if (low_valid) begin
          st_nxt = DACR_ST_LOW;
        end
      end
      default: st_nxt = DACR_ST_LOW;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_r <= DACR_ST_WAIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || pin_rstn_s) begin
      low_cnt_r <= 6'h00;
    end else if (!low_valid) begin
      low_cnt_r <= low_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || st_r != DACR_ST_WAIT || !both_lock) begin
      lock_cnt_r <= 12'h000;
    end else if (!lock_done) begin
      lock_cnt_r <= lock_cnt_r + 12'h001;
    end
  end

  // internal reset held until the run state
  assign o_int_rstn   = (st_r == DACR_ST_RUN);
  assign o_init_state = (st_r == DACR_ST_RUN);

  // host registers
  logic [23:0] core_run_r;
  logic [7:0]  msel_r;
  logic [1:0]  dsel_r;
  logic [7:0]  clk_en_r;
  logic [3:0]  tun_cur_r;
  logic        tun_fast_r;
  logic [1:0]  aud_src_r;
  logic [1:0]  aud_rate_r;
  logic [1:0]  aud_mult_r;
  logic        run_written_r;
  logic        wr_run;
  logic        wr_pll;
  logic        wr_en;
  logic        wr_tun;
  logic        wr_aud;

  assign wr_run = i_reg_wr && (i_reg_addr == OFS_CORE_RUN);
  assign wr_pll = i_reg_wr && (i_reg_addr == OFS_CORE_PLL);
  assign wr_en  = i_reg_wr && (i_reg_addr == OFS_CLK_ENABLE);
  assign wr_tun = i_reg_wr && (i_reg_addr == OFS_TUNER_CTL);
  assign wr_aud = i_reg_wr && (i_reg_addr == OFS_AUDIO_CTL);

  always_ff @(posedge i_sys_clk) begin
    // every host bit back to its default
    if (seq_rst) begin
      core_run_r    <= CORE_RUN_RST;
      // defaults 188 and divide-by-two: 130 MHz
      msel_r        <= CORE_MSEL_RST;
      dsel_r        <= CORE_DSEL_RST;
      clk_en_r      <= CLK_ENABLE_RST;
      tun_cur_r     <= TUNER_CUR_RST;
      tun_fast_r    <= TUNER_FAST_RST;
      aud_src_r     <= AUDIO_SRC_RST;
      aud_rate_r    <= AUDIO_RATE_RST;
      aud_mult_r    <= AUDIO_MULT_RST;
      run_written_r <= 1'b0;
    end else begin
      // first write releases the core counters
      if (wr_run) begin
        core_run_r    <= i_reg_wdata;
        run_written_r <= 1'b1;
      end
      if (wr_pll) begin
        msel_r <= i_reg_wdata[7:0];
        dsel_r <= i_reg_wdata[9:8];
      end
      if (wr_en) begin
        clk_en_r <= i_reg_wdata[7:0];
      end
      // drive level and rate chosen by host
      if (wr_tun) begin
        tun_cur_r  <= i_reg_wdata[3:0];
        tun_fast_r <= i_reg_wdata[4];
      end
      if (wr_aud) begin
        aud_src_r  <= i_reg_wdata[1:0];
        aud_rate_r <= i_reg_wdata[3:2];
        aud_mult_r <= i_reg_wdata[5:4];
      end
    end
  end

  // counters held at zero while set
  assign o_core_run_hold = !run_written_r || !o_int_rstn;
  assign o_clk_enable    = clk_en_r & {8{o_int_rstn}};
  assign o_tuner_current = tun_cur_r;

  assign o_core_msel = msel_r;
  assign o_core_dsel = dsel_r;
  assign o_core_mult = 9'(CORE_M_BASE) + {1'b0, msel_r};

  // reference divider by four for the core pll
  logic [1:0] ref_div_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ref_div_r <= 2'h0;
    end else begin
      ref_div_r <= ref_div_r + 2'h1;
    end
  end
  assign o_core_ref_clk = ref_div_r[1];

  // audio source activity
  logic        ws_d_r;
  logic        fs_d_r;
  logic [11:0] idle_cnt_r;
  logic        ext_edge;
  logic        src_lost;
  logic        fallback_r;

  assign ext_edge = (aud_src_r == DACR_SRC_WS)  ? (ws_s & ~ws_d_r) :
                    (aud_src_r == DACR_SRC_SYS) ? (fsys_s & ~fs_d_r) : 1'b1;
  assign src_lost = (idle_cnt_r >= 12'(LOSS_CYC - 1)) & ~ext_edge;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ws_d_r <= 1'b0;
      fs_d_r <= 1'b0;
    end else begin
      ws_d_r <= ws_s;
      fs_d_r <= fsys_s;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (seq_rst || ext_edge) begin
      idle_cnt_r <= 12'h000;
    end else if (!src_lost) begin
      idle_cnt_r <= idle_cnt_r + 12'h001;
    end
  end

  // stopped source falls back, keeps target rate
  always_ff @(posedge i_sys_clk) begin
    if (seq_rst) begin
      fallback_r <= 1'b0;
    end else if (src_lost) begin
      fallback_r <= 1'b1;
    end else if (ext_edge || wr_aud) begin
      fallback_r <= 1'b0;
    end
  end

  // crystal source presets the chosen target rate
  // external sources: the pll locks to the pin; rate stays, except a system-rate 96k code goes out as 48k
  // the analog loop tolerates twenty percent; no digital check
  // output is 512 times the rate code below
  assign o_audio_src      = fallback_r ? DACR_SRC_XTAL : aud_src_r;
  assign o_audio_rate     = (aud_src_r == DACR_SRC_SYS && aud_rate_r == RATE_96K)
                            ? RATE_48K : aud_rate_r;
  assign o_audio_in_mult  = aud_mult_r;
  assign o_audio_fallback = fallback_r;

  // tuner divider: 100 or 400 kHz
  logic [7:0] tun_cnt_r;
  logic       tun_div_r;
  logic       tun_out_r;
  logic [7:0] tun_half;
  assign tun_half = tun_fast_r ? 8'(TUNER_FAST_HALF - 1) : 8'(TUNER_SLOW_HALF - 1);

  always_ff @(posedge i_sys_clk) begin
    if (seq_rst || !clk_en_r[0]) begin
      tun_cnt_r <= 8'h00;
      tun_div_r <= 1'b0;
    end else if (tun_cnt_r >= tun_half) begin
      tun_cnt_r <= 8'h00;
      tun_div_r <= ~tun_div_r;
    end else begin
      tun_cnt_r <= tun_cnt_r + 8'h01;
    end
  end

  // retime on the clean clock before the drivers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      tun_out_r <= 1'b0;
    end else begin
      tun_out_r <= tun_div_r;
    end
  end
  assign o_tuner_clk_p = tun_out_r;
  assign o_tuner_clk_n = ~tun_out_r;

  // register read port: one cycle after the strobe
  logic [23:0] rd_mux;
  assign rd_mux =
    (i_reg_addr == OFS_CORE_RUN)   ? core_run_r :
    (i_reg_addr == OFS_CORE_PLL)   ? {14'h0000, dsel_r, msel_r} :
    (i_reg_addr == OFS_CLK_ENABLE) ? {16'h0000, clk_en_r} :
    (i_reg_addr == OFS_TUNER_CTL)  ? {19'h00000, tun_fast_r, tun_cur_r} :
    (i_reg_addr == OFS_AUDIO_CTL)  ? {18'h00000, aud_mult_r, aud_rate_r, aud_src_r} :
    (i_reg_addr == OFS_STATUS)     ? {19'h00000, fallback_r, o_int_rstn,
                                      i_audio_pll_lock, i_core_pll_lock, run_written_r} :
    24'h000000;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_reg_rdata  <= 24'h000000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= i_reg_rd ? rd_mux : o_reg_rdata;
      o_reg_rvalid <= i_reg_rd;
    end
  end

endmodule : dacr_clock_reset
`default_nettype wire

// File: verification/dacr_far_model.sv
/*
  Far-side model: analog pll lock reporting and the external audio clocks.
  Assumes the bench scales the external clock rates to the loss window.
*/
`timescale 1ns/100ps
`default_nettype none
module dacr_far_model #(
  parameter int unsigned WS_HALF = 8,
  parameter int unsigned SR_HALF = 3
) (
  // clock and controls from the bench
  input  wire logic i_sys_clk,
  input  wire logic i_pll_run,
  input  wire logic i_ws_run,
  // outputs toward the block
  output var  logic o_core_pll_lock,
  output var  logic o_audio_pll_lock,
  output var  logic o_ws,
  output var  logic o_sr
);
  logic [4:0] lk_r = 5'h00;
  logic [7:0] ws_r = 8'h00;
  logic [7:0] sr_r = 8'h00;
  initial o_ws = 1'b0;
  initial o_sr = 1'b0;
  // lock comes some cycles after the plls start, audio later than core
  always_ff @(posedge i_sys_clk) begin
    lk_r <= !i_pll_run ? 5'h00 : (lk_r == 5'h1f) ? lk_r : lk_r + 5'h01;
  end
  assign o_core_pll_lock  = (lk_r >= 5'h08);
  assign o_audio_pll_lock = (lk_r >= 5'h0c);
  // word clock, stands still when stopped
  always @(posedge i_sys_clk) begin
    if (i_ws_run) begin
      ws_r <= (ws_r == WS_HALF - 1) ? 8'h00 : ws_r + 8'h01;
      if (ws_r == WS_HALF - 1) o_ws <= ~o_ws;
    end
  end
  always @(posedge i_sys_clk) begin
    sr_r <= (sr_r == SR_HALF - 1) ? 8'h00 : sr_r + 8'h01;
    if (sr_r == SR_HALF - 1) o_sr <= ~o_sr;
  end
endmodule : dacr_far_model
`default_nettype wire

// File: verification/dacr_clock_reset_monitor.sv
/*
  Port checker for the clock and reset generator.
  Assumes binding onto dacr_clock_reset; one clock, sync active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module dacr_clock_reset_monitor
  import dacr_pkg::*;
#(
  parameter int unsigned POST_LOCK_CYC = RST_POST_LOCK
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic       i_external_reset_low,
  input wire logic       i_reg_rd,
  input wire logic       o_reg_rvalid,
  input wire logic       i_core_pll_lock,
  input wire logic       i_audio_pll_lock,
  input wire logic       o_core_ref_clk,
  input wire logic [7:0] o_core_msel,
  input wire logic [8:0] o_core_mult,
  input wire logic [1:0] o_audio_src,
  input wire logic [1:0] o_audio_rate,
  input wire logic       o_audio_fallback,
  input wire logic       o_tuner_clk_p,
  input wire logic       o_tuner_clk_n,
  input wire logic [7:0] o_clk_enable,
  input wire logic       o_int_rstn
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [15:0] lk_cnt;
  logic [15:0] low_run;
  logic        pin_q;
  // consecutive locked cycles, and length of the latest pin-low run
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || !(i_core_pll_lock && i_audio_pll_lock)) lk_cnt <= 16'h0000;
    else if (lk_cnt != 16'hffff) lk_cnt <= lk_cnt + 16'h0001;
  end
  always_ff @(posedge i_sys_clk) begin
    pin_q <= i_external_reset_low;
    if (!i_external_reset_low)
      low_run <= pin_q ? 16'h0001 : (low_run == 16'hffff) ? low_run : low_run + 16'h0001;
  end
  property p_ref_div;
    $rose(o_core_ref_clk) |=> o_core_ref_clk ##1 !o_core_ref_clk [*2] ##1 o_core_ref_clk;
  endproperty
  property p_mult;
    o_core_mult == 9'd212 + {1'b0, o_core_msel};
  endproperty
  property p_fallback;
    o_audio_fallback |-> o_audio_src == DACR_SRC_XTAL;
  endproperty
  property p_sys_rate;
    o_audio_src == DACR_SRC_SYS |-> o_audio_rate != RATE_96K;
  endproperty
  property p_tuner_cmp;
    o_tuner_clk_p != o_tuner_clk_n;
  endproperty
  property p_tuner_hold;
    $changed(o_tuner_clk_p) |=> $stable(o_tuner_clk_p) [*8];
  endproperty
  property p_short_pulse;
    $fell(o_int_rstn) |-> low_run >= RST_MIN_LOW;
  endproperty
  property p_post_lock;
    $rose(o_int_rstn) |-> lk_cnt >= POST_LOCK_CYC;
  endproperty
  property p_gate;
    !o_int_rstn |-> o_clk_enable == 8'h00;
  endproperty
  property p_rvalid;
    o_reg_rvalid == $past(i_reg_rd);
  endproperty
  a_ref_div: assert property (p_ref_div) else $error("core ref clock not quarter rate");
  a_mult: assert property (p_mult) else $error("multiplier mismatch");
  a_fallback: assert property (p_fallback) else $error("fallback not on crystal");
  a_sys_rate: assert property (p_sys_rate) else $error("system rate above 48k");
  a_tuner_cmp: assert property (p_tuner_cmp) else $error("tuner pair not complementary");
  a_tuner_hold: assert property (p_tuner_hold) else $error("tuner clock too fast");
  a_short_pulse: assert property (p_short_pulse) else $error("short pin pulse reset");
  a_post_lock: assert property (p_post_lock) else $error("early reset release");
  a_gate: assert property (p_gate) else $error("clock enable during reset");
  a_rvalid: assert property (p_rvalid) else $error("read answer timing");
  c_release: cover property ($rose(o_int_rstn));
  c_fallback: cover property ($rose(o_audio_fallback));
  c_pin_reset: cover property ($fell(o_int_rstn));
endmodule : dacr_clock_reset_monitor
bind dacr_clock_reset dacr_clock_reset_monitor #(.POST_LOCK_CYC(POST_LOCK_CYC)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_external_reset_low(i_external_reset_low),
  .i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid), .i_core_pll_lock(i_core_pll_lock),
  .i_audio_pll_lock(i_audio_pll_lock), .o_core_ref_clk(o_core_ref_clk),
  .o_core_msel(o_core_msel), .o_core_mult(o_core_mult), .o_audio_src(o_audio_src),
  .o_audio_rate(o_audio_rate), .o_audio_fallback(o_audio_fallback),
  .o_tuner_clk_p(o_tuner_clk_p), .o_tuner_clk_n(o_tuner_clk_n),
  .o_clk_enable(o_clk_enable), .o_int_rstn(o_int_rstn));
`default_nettype wire

// File: verification/dacr_clock_reset_tb.sv
/*
  Self-checking bench for the clock and reset generator.
  Assumes the far model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
module dacr_clock_reset_tb;
  import dacr_pkg::*;
  localparam int unsigned PL = 16;
  logic        i_sys_clk = 1'b0;
  logic        rstn = 1'b0, pin = 1'b1, rd = 1'b0, wr = 1'b0, pll_run = 1'b0, ws_run = 1'b0;
  logic [23:0] addr = 24'h0, wdata = 24'h0, rdata;
  logic        rvalid, cl, al, ws, sr, ref_clk, fb, tp, tn, int_rstn, hold, init;
  logic [7:0]  msel, clk_en;
  logic [1:0]  dsel, src, rate, imult;
  logic [8:0]  mult;
  logic [3:0]  cur;
  int          miscompares = 0, checks = 0, n, g;
  always #12.5 i_sys_clk = ~i_sys_clk;
  dacr_clock_reset #(.POST_LOCK_CYC(PL), .LOSS_CYC(32)) DUT (.i_sys_clk(i_sys_clk),
    .i_rstn(rstn), .i_external_reset_low(pin), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_core_pll_lock(cl), .i_audio_pll_lock(al), .o_core_ref_clk(ref_clk),
    .o_core_msel(msel), .o_core_dsel(dsel), .o_core_mult(mult), .o_audio_src(src),
    .o_audio_rate(rate), .o_audio_in_mult(imult), .o_audio_fallback(fb),
    .i_host_word_clock_input(ws), .i_system_rate_input(sr), .o_tuner_clk_p(tp),
    .o_tuner_clk_n(tn), .o_tuner_current(cur), .o_clk_enable(clk_en),
    .o_int_rstn(int_rstn), .o_init_state(init), .o_core_run_hold(hold));
  dacr_far_model u_far (.i_sys_clk(i_sys_clk), .i_pll_run(pll_run), .i_ws_run(ws_run),
    .o_core_pll_lock(cl), .o_audio_pll_lock(al), .o_ws(ws), .o_sr(sr));
  task end_of_test;
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
    g++;
    if (g > 2000) begin
      miscompares++;
      end_of_test;
    end
  endtask : tick
  task wreg(input logic [23:0] a, input logic [23:0] d);
    @(posedge i_sys_clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge i_sys_clk);
    wr <= 1'b0;
    tick(1);
  endtask : wreg
  task rreg(input logic [23:0] a, input logic [23:0] exp, input string nm);
    @(posedge i_sys_clk);
    rd <= 1'b1; addr <= a;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1;
    chk(rvalid, 24'h1, "rvalid");
    chk(rdata, exp, nm);
  endtask : rreg
  task wait_locks;
    g = 0;
    while (!(cl === 1'b1 && al === 1'b1)) tick(1);
  endtask : wait_locks
  task wait_run;
    g = 0;
    n = 0;
    while (int_rstn !== 1'b1) begin
      tick(1);
      n++;
    end
  endtask : wait_run
  // one full high phase of the positive tuner output, in cycles
  task half(input int exp);
    g = 0;
    while (tp !== 1'b0) tick(1);
    while (tp !== 1'b1) tick(1);
    n = 0;
    while (tp === 1'b1) begin
      tick(1);
      n++;
    end
    chk(n, exp, "tuner half period");
  endtask : half
  initial begin
    repeat (16) @(posedge i_sys_clk);
    rstn <= 1'b1;
    pll_run <= 1'b1;
    wait_locks;
    tick(8);
    chk(int_rstn, 24'h0, "int_rstn early");
    pll_run <= 1'b0;
    @(posedge i_sys_clk);
    pll_run <= 1'b1;
    tick(2);
    wait_locks;
    wait_run;
    chk((n >= PL && n <= PL + 2), 24'h1, "post lock count");
    chk(init, 24'h1, "init state");
    rreg(OFS_CORE_PLL, 24'h0002bc, "core pll reset");
    chk(mult, 24'd400, "core mult");
    rreg(OFS_CLK_ENABLE, 24'h0000ff, "clk enable reset");
    rreg(OFS_TUNER_CTL, 24'h000004, "tuner reset");
    rreg(OFS_AUDIO_CTL, 24'h000004, "audio reset");
    rreg(24'h000030, 24'h000000, "unmapped");
    rreg(OFS_STATUS, 24'h00000e, "status");
    chk(hold, 24'h1, "run hold");
    wreg(OFS_CORE_RUN, 24'h000001);
    chk(hold, 24'h0, "run hold released");
    wreg(OFS_CORE_PLL, 24'h0003d0);
    chk(mult, 24'd420, "core mult");
    chk(dsel, 24'h3, "core dsel");
    half(TUNER_SLOW_HALF);
    wreg(OFS_TUNER_CTL, 24'h00001a);
    tick(120);
    half(TUNER_FAST_HALF);
    chk(cur, 24'ha, "tuner current");
    wreg(OFS_CLK_ENABLE, 24'h0000fe);
    tick(60);
    chk({tp, clk_en}, {1'b0, 8'hfe}, "tuner gated");
    wreg(OFS_CLK_ENABLE, 24'h0000ff);
    ws_run <= 1'b1;
    wreg(OFS_AUDIO_CTL, 24'h000009);
    tick(100);
    chk({fb, src}, {1'b0, 2'h1}, "word clock source");
    ws_run <= 1'b0;
    tick(60);
    chk({fb, src, rate}, {1'b1, 2'h0, RATE_96K}, "fallback");
    ws_run <= 1'b1;
    tick(40);
    chk(fb, 24'h0, "fallback cleared");
    wreg(OFS_AUDIO_CTL, 24'h00002a);
    tick(100);
    chk({fb, src, rate, imult}, {1'b0, 2'h2, RATE_48K, 2'h2}, "system rate");
    @(posedge i_sys_clk);
    pin <= 1'b0;
    tick(20);
    @(posedge i_sys_clk);
    pin <= 1'b1;
    tick(10);
    chk(int_rstn, 24'h1, "short pulse");
    @(posedge i_sys_clk);
    pin <= 1'b0;
    tick(50);
    chk({int_rstn, clk_en}, 24'h0, "pin reset");
    @(posedge i_sys_clk);
    pin <= 1'b1;
    wait_run;
    rreg(OFS_CORE_PLL, 24'h0002bc, "core pll after pin reset");
    chk(hold, 24'h1, "run hold again");
    end_of_test;
  end
endmodule : dacr_clock_reset_tb
`default_nettype wire
